// >>> design/bio_ports.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - set, clear or test any of sixteen pins of ports a to d by index.
// - index upper two bits pick port, lower two bits pick bit.
// - all bidirectional output latches go to ones during reset.
// - ports a and b feed analog inputs; reset selects channel zero.
// - dual-clock mode gives port d upper pins to the slow crystal.
// - watchdog pin drives watchdog output AND its latch.
// - falling edge on irq one pin always raises irq one; master enable accepts.
// - falling edge on irq two pin raises irq two; master enable and enable bit 0 both gate acceptance.
// - serial-shared port has three pins with latches; serial use needs ones.
// - serial port bit 3 has no pin; writes alter core state, reads undefined.
// - ports e, f, g are latched 4-bit bidirectional ports reset to ones.
// - sense input reads inverted at lo address bit 0 and hi address bit 3.
// - sense input pin is shared with the hold request input.
module bio_ports (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [3:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [3:0] rdata,
	// bidirectional ports: drive level, enable, pin level
	input  wire logic [3:0] bidir_port_a_i,
	output logic      [3:0] bidir_port_a_o,
	output logic      [3:0] bidir_port_a_oe,
	input  wire logic [3:0] bidir_port_b_i,
	output logic      [3:0] bidir_port_b_o,
	output logic      [3:0] bidir_port_b_oe,
	input  wire logic [3:0] bidir_port_c_i,
	output logic      [3:0] bidir_port_c_o,
	output logic      [3:0] bidir_port_c_oe,
	input  wire logic [3:0] bidir_port_d_i,
	output logic      [3:0] bidir_port_d_o,
	output logic      [3:0] bidir_port_d_oe,
	input  wire logic [3:0] irq_timer_shared_port_i,
	output logic      [3:0] irq_timer_shared_port_o,
	output logic      [3:0] irq_timer_shared_port_oe,
	input  wire logic [2:0] serial_shared_port_i,
	output logic      [2:0] serial_shared_port_o,
	output logic      [2:0] serial_shared_port_oe,
	input  wire logic [3:0] bidir_port_e_i,
	output logic      [3:0] bidir_port_e_o,
	output logic      [3:0] bidir_port_e_oe,
	input  wire logic [3:0] bidir_port_f_i,
	output logic      [3:0] bidir_port_f_o,
	output logic      [3:0] bidir_port_f_oe,
	input  wire logic [3:0] bidir_port_g_i,
	output logic      [3:0] bidir_port_g_o,
	output logic      [3:0] bidir_port_g_oe,
	// shared functions
	input  wire logic       inverted_sense_input,
	input  wire logic       watchdog_level,
	output logic            hold_request,
	output logic            dual_clock_mode,
	output logic            slow_xtal_enable,
	output logic      [2:0] analog_channel_sel,
	output logic            serial_hidden_bit,
	output logic            serial_hidden_wr,
	output logic            ext_irq_one_accept,
	output logic            ext_irq_two_accept,
	output logic            irq
);
	// ****************************************
	// declarations
	// ****************************************
	logic [3:0]  latch_reg [0:bio_pkg::NUM_PORTS-1];
	logic [3:0]  oe_reg    [0:bio_pkg::NUM_PORTS-1];
	logic [3:0]  pin_lvl   [0:bio_pkg::NUM_PORTS-1];
	logic [35:0] pin_async;
	logic [35:0] pin_sync;
	logic [3:0]  index_reg;
	logic        dual_reg;
	logic [1:0]  stat_reg;
	logic [1:0]  mask_reg;
	logic [2:0]  adc_sel_reg;
	logic [3:0]  int_en_reg;
	logic [3:0]  rdata_reg;
	logic        hold_reg;
	logic        hid_wr_reg;
	logic        accept_one_reg;
	logic        accept_two_reg;
	logic        irq_reg;
	logic [1:0]  irq_pins;
	logic [1:0]  irq_fall;
	logic [1:0]  stat_next;
	logic [3:0]  rdata_next;
	logic        port_hit;
	logic [3:0]  port_idx;
	logic        bitop_wr;
	logic [1:0]  bit_port;
	logic [1:0]  bit_pos;
	logic        sense_lvl;

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	assign pin_async = {inverted_sense_input, bidir_port_g_i, bidir_port_f_i, bidir_port_e_i,
		serial_shared_port_i, irq_timer_shared_port_i, bidir_port_d_i, bidir_port_c_i,
		bidir_port_b_i, bidir_port_a_i};

	bio_sync #(
		.W (bio_pkg::PIN_SYNC_W)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (pin_async),
		.sync_out (pin_sync)
	);

	assign pin_lvl[0] = pin_sync[3:0];
	assign pin_lvl[1] = pin_sync[7:4];
	assign pin_lvl[2] = pin_sync[11:8];
	assign pin_lvl[3] = pin_sync[15:12];
	assign pin_lvl[4] = pin_sync[19:16];
	// bit 3 has no pin; its read is undefined, zero is returned
	assign pin_lvl[5] = {1'b0, pin_sync[22:20]};
	assign pin_lvl[6] = pin_sync[26:23];
	assign pin_lvl[7] = pin_sync[30:27];
	assign pin_lvl[8] = pin_sync[34:31];
	assign sense_lvl  = pin_sync[35];

	// edges are caught even while the pin serves as a plain port bit
	assign irq_pins = {pin_lvl[bio_pkg::PORT_IRQ][bio_pkg::IRQ_TWO_BIT],
		pin_lvl[bio_pkg::PORT_IRQ][bio_pkg::IRQ_ONE_BIT]};

	bio_fall_edge u_edge (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.level   (irq_pins),
		.fall    (irq_fall)
	);

	// ****************************************
	// address decode
	// ****************************************
	always_comb begin
		port_hit = (addr >= bio_pkg::ADDR_PORT_BASE) && (addr <= bio_pkg::ADDR_PORT_LAST);
		port_idx = 4'(addr - bio_pkg::ADDR_PORT_BASE);
		bitop_wr = wr_stb && (addr == bio_pkg::ADDR_BITOP);
		bit_port = index_reg[3:2];
		bit_pos  = index_reg[1:0];
	end

	// ****************************************
	// output latches
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < bio_pkg::NUM_PORTS; gi++) begin : g_latch
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					latch_reg[gi] <= bio_pkg::LATCH_RST;
				end else if (wr_stb && port_hit && (port_idx == 4'(gi))) begin
					latch_reg[gi] <= wdata;
				end else if (bitop_wr && (gi < 4) && (bit_port == 2'(gi))) begin
					// indexed bit access reaches only the first four ports
					if (wdata[bio_pkg::BITOP_SET]) begin
						latch_reg[gi][bit_pos] <= 1'b1;
					end else if (wdata[bio_pkg::BITOP_CLR]) begin
						latch_reg[gi][bit_pos] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// pin drive enables
	// ****************************************
	// a zero latch pulls the pin low; a one releases it so it can be read
	generate
		for (gi = 0; gi < bio_pkg::NUM_PORTS; gi++) begin : g_oe
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					oe_reg[gi] <= bio_pkg::ZERO_RST;
				end else if (gi == bio_pkg::PORT_D) begin
					oe_reg[gi][0] <= ~latch_reg[gi][0];
					// watchdog low pulls the pin whatever the latch holds
					oe_reg[gi][bio_pkg::WDT_BIT] <= ~(latch_reg[gi][bio_pkg::WDT_BIT]
						& watchdog_level);
					// crystal pins are never driven by port logic in dual-clock mode
					oe_reg[gi][bio_pkg::XTAL_IN_BIT] <= ~dual_reg
						& ~latch_reg[gi][bio_pkg::XTAL_IN_BIT];
					oe_reg[gi][bio_pkg::XTAL_OUT_BIT] <= ~dual_reg
						& ~latch_reg[gi][bio_pkg::XTAL_OUT_BIT];
				end else if (gi == bio_pkg::PORT_SER) begin
					oe_reg[gi] <= {1'b0, ~latch_reg[gi][2:0]};
				end else begin
					oe_reg[gi] <= ~latch_reg[gi];
				end
			end
		end
	endgenerate

	assign bidir_port_a_o           = latch_reg[0];
	assign bidir_port_a_oe          = oe_reg[0];
	assign bidir_port_b_o           = latch_reg[1];
	assign bidir_port_b_oe          = oe_reg[1];
	assign bidir_port_c_o           = latch_reg[2];
	assign bidir_port_c_oe          = oe_reg[2];
	assign bidir_port_d_o           = latch_reg[3];
	assign bidir_port_d_oe          = oe_reg[3];
	assign irq_timer_shared_port_o  = latch_reg[4];
	assign irq_timer_shared_port_oe = oe_reg[4];
	assign serial_shared_port_o     = latch_reg[5][2:0];
	assign serial_shared_port_oe    = oe_reg[5][2:0];
	assign bidir_port_e_o           = latch_reg[6];
	assign bidir_port_e_oe          = oe_reg[6];
	assign bidir_port_f_o           = latch_reg[7];
	assign bidir_port_f_oe          = oe_reg[7];
	assign bidir_port_g_o           = latch_reg[8];
	assign bidir_port_g_oe          = oe_reg[8];
	assign serial_hidden_bit        = latch_reg[bio_pkg::PORT_SER][bio_pkg::SER_HID_BIT];

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			index_reg <= bio_pkg::ZERO_RST;
		end else if (wr_stb && (addr == bio_pkg::ADDR_INDEX)) begin
			index_reg <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dual_reg <= 1'b0;
		end else if (wr_stb && (addr == bio_pkg::ADDR_CTRL)) begin
			dual_reg <= wdata[bio_pkg::CTRL_DUAL];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			adc_sel_reg <= bio_pkg::ADC_SEL_RST;
		end else if (wr_stb && (addr == bio_pkg::ADDR_ADC_SEL)) begin
			adc_sel_reg <= wdata[2:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			int_en_reg <= bio_pkg::ZERO_RST;
		end else if (wr_stb && (addr == bio_pkg::ADDR_INT_EN)) begin
			int_en_reg <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mask_reg <= 2'h0;
		end else if (wr_stb && (addr == bio_pkg::ADDR_IRQ_MASK)) begin
			mask_reg <= wdata[1:0];
		end
	end

	// core is told of every write to the pinless serial bit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hid_wr_reg <= 1'b0;
		end else begin
			hid_wr_reg <= wr_stb && (addr == bio_pkg::ADDR_PORT_BASE + 8'(bio_pkg::PORT_SER));
		end
	end

	// ****************************************
	// interrupt status
	// ****************************************
	// a new edge wins over a write-one-to-clear in the same cycle
	always_comb begin
		stat_next = stat_reg;
		if (wr_stb && (addr == bio_pkg::ADDR_IRQ_STAT)) begin
			stat_next = stat_reg & ~wdata[1:0];
		end
		if (irq_fall[0]) begin
			stat_next[bio_pkg::STAT_IRQ_ONE] = 1'b1;
		end
		if (irq_fall[1]) begin
			stat_next[bio_pkg::STAT_IRQ_TWO] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stat_reg <= 2'h0;
		end else begin
			stat_reg <= stat_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			accept_one_reg <= 1'b0;
			accept_two_reg <= 1'b0;
			irq_reg        <= 1'b0;
		end else begin
			accept_one_reg <= stat_next[bio_pkg::STAT_IRQ_ONE]
				& int_en_reg[bio_pkg::INTEN_MASTER];
			accept_two_reg <= stat_next[bio_pkg::STAT_IRQ_TWO]
				& int_en_reg[bio_pkg::INTEN_MASTER] & int_en_reg[bio_pkg::INTEN_TWO];
			irq_reg        <= |(stat_next & mask_reg);
		end
	end

	// ****************************************
	// sense input and misc outputs
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hold_reg <= 1'b0;
		end else begin
			hold_reg <= sense_lvl;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// bidirectional ports read the pin, not the latch
	always_comb begin
		rdata_next = bio_pkg::ZERO_RST;
		if (port_hit) begin
			rdata_next = pin_lvl[port_idx];
		end else if (addr == bio_pkg::ADDR_SENSE_LO) begin
			rdata_next = {3'h0, ~sense_lvl};
		end else if (addr == bio_pkg::ADDR_SENSE_HI) begin
			rdata_next = {~sense_lvl, 3'h0};
		end else if (addr == bio_pkg::ADDR_INDEX) begin
			rdata_next = index_reg;
		end else if (addr == bio_pkg::ADDR_BITOP) begin
			rdata_next = {3'h0, pin_lvl[bit_port][bit_pos]};
		end else if (addr == bio_pkg::ADDR_CTRL) begin
			rdata_next = {3'h0, dual_reg};
		end else if (addr == bio_pkg::ADDR_IRQ_STAT) begin
			rdata_next = {2'h0, stat_reg};
		end else if (addr == bio_pkg::ADDR_IRQ_MASK) begin
			rdata_next = {2'h0, mask_reg};
		end else if (addr == bio_pkg::ADDR_ADC_SEL) begin
			rdata_next = {1'b0, adc_sel_reg};
		end else if (addr == bio_pkg::ADDR_INT_EN) begin
			rdata_next = int_en_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_reg <= bio_pkg::ZERO_RST;
		end else if (rd_stb) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= bio_pkg::ZERO_RST;
		end
	end

	assign rdata              = rdata_reg;
	assign hold_request       = hold_reg;
	assign dual_clock_mode    = dual_reg;
	assign slow_xtal_enable   = dual_reg;
	assign analog_channel_sel = adc_sel_reg;
	assign serial_hidden_wr   = hid_wr_reg;
	assign ext_irq_one_accept = accept_one_reg;
	assign ext_irq_two_accept = accept_two_reg;
	assign irq                = irq_reg;
endmodule
`default_nettype wire

// >>> design/bio_pkg.sv
package bio_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int          NUM_PORTS    = 9;
	localparam int          PORT_W       = 4;
	localparam int          PIN_SYNC_W   = 36;
	localparam int          PORT_A       = 0;
	localparam int          PORT_B       = 1;
	localparam int          PORT_D       = 3;
	localparam int          PORT_IRQ     = 4;
	localparam int          PORT_SER     = 5;
	localparam int          WDT_BIT      = 1;
	localparam int          XTAL_IN_BIT  = 2;
	localparam int          XTAL_OUT_BIT = 3;
	localparam int          IRQ_ONE_BIT  = 2;
	localparam int          IRQ_TWO_BIT  = 0;
	localparam int          SER_HID_BIT  = 3;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0]  ADDR_PORT_BASE  = 8'h04;
	localparam logic [7:0]  ADDR_PORT_LAST  = 8'h0C;
	localparam logic [7:0]  ADDR_SENSE_LO   = 8'h0E;
	localparam logic [7:0]  ADDR_SENSE_HI   = 8'h10;
	localparam logic [7:0]  ADDR_INDEX      = 8'h20;
	localparam logic [7:0]  ADDR_BITOP      = 8'h21;
	localparam logic [7:0]  ADDR_CTRL       = 8'h22;
	localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h23;
	localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h24;
	localparam logic [7:0]  ADDR_ADC_SEL    = 8'h25;
	localparam logic [7:0]  ADDR_INT_EN     = 8'h26;
	// ****************************************
	// field positions
	// ****************************************
	localparam int          BITOP_SET    = 0;
	localparam int          BITOP_CLR    = 1;
	localparam int          CTRL_DUAL    = 0;
	localparam int          STAT_IRQ_ONE = 0;
	localparam int          STAT_IRQ_TWO = 1;
	localparam int          INTEN_TWO    = 0;
	localparam int          INTEN_MASTER = 3;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [3:0]  LATCH_RST    = 4'hF;
	localparam logic [3:0]  ZERO_RST     = 4'h0;
	localparam logic [2:0]  ADC_SEL_RST  = 3'h0;
	localparam logic [35:0] PIN_RST      = 36'hF_FFFF_FFFF;
	localparam logic [1:0]  EDGE_RST     = 2'h3;
endpackage

// >>> design/bio_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bio_sync #(
	parameter int W = 36
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	// ****************************************
	// two-stage synchroniser
	// ****************************************
	logic [W-1:0] stage1_reg;

	// pins rest high (released), so reset to ones avoids false falling edges
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stage1_reg <= W'(bio_pkg::PIN_RST);
			sync_out   <= W'(bio_pkg::PIN_RST);
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

// >>> design/bio_fall_edge.sv
`timescale 1ns/1ps
`default_nettype none
module bio_fall_edge (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] level,
	output logic      [1:0] fall
);
	// ****************************************
	// falling edge detect, one pulse per edge
	// ****************************************
	logic [1:0] prev_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prev_reg <= bio_pkg::EDGE_RST;
		end else begin
			prev_reg <= level;
		end
	end

	assign fall = prev_reg & ~level;
endmodule
`default_nettype wire

// >>> bench/bio_pins.sv
`timescale 1ns/1ps
`default_nettype none
module bio_pins (
	input  wire logic [35:0] drive_en,
	input  wire logic [35:0] pull_low,
	output logic      [35:0] pin_level
);
	// ****************************************
	// board pins with pull-ups
	// ****************************************
	// the device only sinks: an enabled pin is pulled low whatever the latch holds,
	// so a watchdog pull on a one latch still reads low; a released pin floats up
	assign pin_level = ~(drive_en | pull_low);
endmodule
`default_nettype wire

// >>> bench/bio_ports_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bio_ports_chk (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [7:0] addr,
	input wire logic [3:0] wdata,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [3:0] rdata,
	input wire logic [3:0] bidir_port_a_o,
	input wire logic [3:0] bidir_port_d_o,
	input wire logic [3:0] bidir_port_d_oe,
	input wire logic [3:0] irq_timer_shared_port_i,
	input wire logic       watchdog_level,
	input wire logic       dual_clock_mode,
	input wire logic [2:0] analog_channel_sel,
	input wire logic       ext_irq_one_accept
);
	// ****************************************
	// shadows and properties
	// ****************************************
	logic [3:0] idx_reg;
	logic [3:0] en_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idx_reg <= 4'h0;
			en_reg  <= 4'h0;
		end else if (wr_stb) begin
			if (addr == bio_pkg::ADDR_INDEX) begin
				idx_reg <= wdata;
			end
			if (addr == bio_pkg::ADDR_INT_EN) begin
				en_reg <= wdata;
			end
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	property p_rst_latch;
		!rst_n |=> bidir_port_a_o == 4'hF && bidir_port_d_o == 4'hF;
	endproperty
	a_rst_latch: assert property (p_rst_latch) else $error("latch not ones after reset");
	property p_rst_adc;
		!rst_n |=> analog_channel_sel == 3'h0;
	endproperty
	a_rst_adc: assert property (p_rst_adc) else $error("channel not zero after reset");
	property p_bit_clr;
		disable iff (!rst_n) wr_stb && addr == bio_pkg::ADDR_BITOP && wdata[1:0] == 2'h2 && idx_reg[3:2] == 2'h0
			|=> !bidir_port_a_o[$past(idx_reg[1:0])];
	endproperty
	a_bit_clr: assert property (p_bit_clr) else $error("indexed clear missed");
	property p_bit_set;
		disable iff (!rst_n) wr_stb && addr == bio_pkg::ADDR_BITOP && wdata[0] && idx_reg[3:2] == 2'h3
			|=> bidir_port_d_o[$past(idx_reg[1:0])];
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("indexed set missed");
	property p_wdt;
		disable iff (!rst_n) $past(rst_n) |-> bidir_port_d_oe[1] == !($past(bidir_port_d_o[1]) && $past(watchdog_level));
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog pin drive wrong");
	property p_xtal;
		disable iff (!rst_n) dual_clock_mode |=> bidir_port_d_oe[3:2] == 2'h0;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal pins driven");
	property p_single;
		disable iff (!rst_n) !dual_clock_mode |=> bidir_port_d_oe[3:2] == ~$past(bidir_port_d_o[3:2]);
	endproperty
	a_single: assert property (p_single) else $error("port pins 3:2 wrong");
	sequence s_fall_one;
		$fell(irq_timer_shared_port_i[bio_pkg::IRQ_ONE_BIT]) && en_reg[bio_pkg::INTEN_MASTER];
	endsequence
	sequence s_accept_one;
		##[3:6] ext_irq_one_accept;
	endsequence
	property p_irq_one;
		disable iff (!rst_n) s_fall_one |-> s_accept_one;
	endproperty
	a_irq_one: assert property (p_irq_one) else $error("irq one not accepted");
	property p_rd_idle;
		disable iff (!rst_n) !rd_stb |=> rdata == 4'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule
bind bio_ports bio_ports_chk i_chk (.ref_clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .bidir_port_a_o,
	.bidir_port_d_o, .bidir_port_d_oe, .irq_timer_shared_port_i, .watchdog_level, .dual_clock_mode,
	.analog_channel_sel, .ext_irq_one_accept);
`default_nettype wire

// >>> bench/test_bit_addressable_io_ports.sv
`timescale 1ns/1ps
`default_nettype none
module test_bit_addressable_io_ports;
	// ****************************************
	// bench
	// ****************************************
	logic        ref_clk;
	logic        rst_n;
	logic [7:0]  addr;
	logic [3:0]  wdata;
	logic        wr_stb;
	logic        rd_stb;
	logic        sense;
	logic        wdt;
	logic        dual;
	logic        hid_exp;
	logic [35:0] pull_low;
	wire  [35:0] po;
	wire  [35:0] poe;
	wire  [35:0] pin;
	wire  [3:0]  rdata;
	wire  [2:0]  adc;
	wire         hold;
	wire         dual_out;
	wire         xtal;
	wire         hid;
	wire         hid_wr;
	wire         acc1;
	wire         acc2;
	wire         irq;
	logic [3:0]  lat [9];
	logic [3:0]  d;
	logic [3:0]  v;
	integer      seed;
	int          miscompares;
	int          total_checks;
	// serial port has three pins; slot 23 is a released dummy
	assign po[23]  = 1'h1;
	assign poe[23] = 1'h0;
	bio_pins i_pins (.drive_en (poe), .pull_low (pull_low), .pin_level (pin));
	bio_ports i_dut (
		.ref_clk (ref_clk), .rst_n (rst_n), .addr (addr), .wdata (wdata),
		.wr_stb (wr_stb), .rd_stb (rd_stb), .rdata (rdata),
		.bidir_port_a_i (pin[3:0]), .bidir_port_a_o (po[3:0]), .bidir_port_a_oe (poe[3:0]),
		.bidir_port_b_i (pin[7:4]), .bidir_port_b_o (po[7:4]), .bidir_port_b_oe (poe[7:4]),
		.bidir_port_c_i (pin[11:8]), .bidir_port_c_o (po[11:8]), .bidir_port_c_oe (poe[11:8]),
		.bidir_port_d_i (pin[15:12]), .bidir_port_d_o (po[15:12]), .bidir_port_d_oe (poe[15:12]),
		.irq_timer_shared_port_i (pin[19:16]), .irq_timer_shared_port_o (po[19:16]),
		.irq_timer_shared_port_oe (poe[19:16]),
		.serial_shared_port_i (pin[22:20]), .serial_shared_port_o (po[22:20]), .serial_shared_port_oe (poe[22:20]),
		.bidir_port_e_i (pin[27:24]), .bidir_port_e_o (po[27:24]), .bidir_port_e_oe (poe[27:24]),
		.bidir_port_f_i (pin[31:28]), .bidir_port_f_o (po[31:28]), .bidir_port_f_oe (poe[31:28]),
		.bidir_port_g_i (pin[35:32]), .bidir_port_g_o (po[35:32]), .bidir_port_g_oe (poe[35:32]),
		.inverted_sense_input (sense), .watchdog_level (wdt), .hold_request (hold),
		.dual_clock_mode (dual_out), .slow_xtal_enable (xtal), .analog_channel_sel (adc),
		.serial_hidden_bit (hid), .serial_hidden_wr (hid_wr), .ext_irq_one_accept (acc1),
		.ext_irq_two_accept (acc2), .irq (irq)
	);
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [3:0] exp_pin(input int p);
		logic [3:0] e;
		e = lat[p] & ~pull_low[p*4+:4];
		if (p == bio_pkg::PORT_D) begin
			e[1] = e[1] & wdt;
			if (dual) e[3:2] = ~pull_low[15:14];
		end
		if (p == bio_pkg::PORT_SER) e[3] = 1'h0;
		return e;
	endfunction
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] dv);
		@(posedge ref_clk);
		addr <= a;
		wdata <= dv;
		wr_stb <= 1'h1;
		@(posedge ref_clk);
		wr_stb <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [3:0] m, input logic [3:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'h1;
		@(posedge ref_clk);
		rd_stb <= 1'h0;
		#1;
		chk("rdata", e, rdata & m);
	endtask
	// pins lag latches by output-enable stage plus two sync stages
	task automatic check_ports;
		repeat (5) @(posedge ref_clk);
		for (int p = 0; p < 9; p++) begin
			chk("latch", lat[p], po[p*4+:4]);
			rdc(bio_pkg::ADDR_PORT_BASE + 8'(p), 4'hF, exp_pin(p));
		end
		chk("hidden", {3'h0, hid_exp}, {3'h0, hid});
	endtask
	task automatic do_reset;
		rst_n <= 1'h0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (int p = 0; p < 9; p++) lat[p] = 4'hF;
		hid_exp = 1'h1;
		dual = 1'h0;
		check_ports;
		chk("adc", 4'h0, {1'h0, adc});
		$display("reset test done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge ref_clk);
		miscompares++;
		conclude;
	end
	initial begin
		seed = 6510;
		miscompares = 0;
		total_checks = 0;
		rst_n = 1'h0;
		addr = 8'h00;
		wdata = 4'h0;
		wr_stb = 1'h0;
		rd_stb = 1'h0;
		sense = 1'h1;
		wdt = 1'h1;
		pull_low = 36'h0;
		do_reset;
		for (int i = 0; i < 6; i++) begin
			pull_low <= 36'({$random(seed), $random(seed)});
			for (int p = 0; p < 9; p++) begin
				d = 4'($random(seed));
				wr(bio_pkg::ADDR_PORT_BASE + 8'(p), d);
				#1;
				chk("hidwr", {3'h0, p == bio_pkg::PORT_SER}, {3'h0, hid_wr});
				lat[p] = (p == bio_pkg::PORT_SER) ? (d | 4'h8) : d;
				if (p == bio_pkg::PORT_SER) hid_exp = d[3];
			end
			check_ports;
		end
		$display("port test done");
		for (int i = 0; i < 24; i++) begin
			v = (i == 0) ? 4'h3 : (i == 1) ? 4'hD : 4'($random(seed));
			d = (i == 0) ? 4'h2 : (i == 1) ? 4'h1 : 4'($random(seed)) & 4'h3;
			wr(bio_pkg::ADDR_INDEX, v);
			wr(bio_pkg::ADDR_BITOP, d);
			if (d[0]) lat[v[3:2]][v[1:0]] = 1'h1;
			else if (d[1]) lat[v[3:2]][v[1:0]] = 1'h0;
			repeat (5) @(posedge ref_clk);
			chk("latch", lat[v[3:2]], po[v[3:2]*4+:4]);
			d = exp_pin(v[3:2]);
			rdc(bio_pkg::ADDR_BITOP, 4'h1, {3'h0, d[v[1:0]]});
		end
		$display("index test done");
		wr(bio_pkg::ADDR_PORT_BASE + 8'h3, 4'hF);
		lat[3] = 4'hF;
		wdt <= 1'h0;
		check_ports;
		wdt <= 1'h1;
		wr(bio_pkg::ADDR_PORT_BASE + 8'h3, 4'h0);
		lat[3] = 4'h0;
		wr(bio_pkg::ADDR_CTRL, 4'h1);
		dual = 1'h1;
		check_ports;
		chk("dual", 4'h3, {2'h0, dual_out, xtal});
		wr(bio_pkg::ADDR_CTRL, 4'h0);
		dual = 1'h0;
		check_ports;
		$display("shared pin test done");
		pull_low <= 36'h0;
		wr(bio_pkg::ADDR_PORT_BASE + 8'h4, 4'hF);
		lat[4] = 4'hF;
		repeat (5) @(posedge ref_clk);
		wr(bio_pkg::ADDR_IRQ_STAT, 4'hF);
		wr(bio_pkg::ADDR_IRQ_MASK, 4'h3);
		wr(bio_pkg::ADDR_INT_EN, 4'h8);
		pull_low[18] <= 1'h1;
		repeat (8) @(posedge ref_clk);
		chk("irq", 4'h5, {1'h0, acc1, acc2, irq});
		pull_low[16] <= 1'h1;
		repeat (8) @(posedge ref_clk);
		rdc(bio_pkg::ADDR_IRQ_STAT, 4'h3, 4'h3);
		chk("irq", 4'h5, {1'h0, acc1, acc2, irq});
		wr(bio_pkg::ADDR_INT_EN, 4'h9);
		repeat (3) @(posedge ref_clk);
		chk("irq", 4'h7, {1'h0, acc1, acc2, irq});
		wr(bio_pkg::ADDR_IRQ_MASK, 4'h0);
		repeat (3) @(posedge ref_clk);
		chk("irq", 4'h6, {1'h0, acc1, acc2, irq});
		wr(bio_pkg::ADDR_IRQ_STAT, 4'h3); // bare acknowledge, nothing else
		repeat (3) @(posedge ref_clk);
		chk("irq", 4'h0, {1'h0, acc1, acc2, irq});
		wr(bio_pkg::ADDR_INT_EN, 4'h0);
		pull_low <= 36'h0;
		$display("interrupt test done");
		for (int s = 0; s < 2; s++) begin
			sense <= s[0]; // single-clock mode only
			repeat (5) @(posedge ref_clk);
			rdc(bio_pkg::ADDR_SENSE_LO, 4'h1, {3'h0, ~s[0]});
			rdc(bio_pkg::ADDR_SENSE_HI, 4'h8, {~s[0], 3'h0});
			chk("hold", {3'h0, s[0]}, {3'h0, hold});
		end
		wr(8'h30, 4'h5);
		rdc(8'h30, 4'hF, 4'h0);
		wr(bio_pkg::ADDR_ADC_SEL, 4'h5); // no conversion runs during port writes
		@(posedge ref_clk);
		chk("adc", 4'h5, {1'h0, adc});
		$display("misc test done");
		do_reset;
		conclude;
	end
endmodule
`default_nettype wire
